// [pkg/rbs_pkg.sv]
package rbs_pkg;

  // =====================================================
  // Geometry
  localparam int BANK_COUNT = 16;
  localparam int BANK_W     = 4;
  localparam int WORD_W     = 32;
  localparam int ACC_W      = 72;
  localparam int GPR_COUNT  = 15;

  // =====================================================
  // Restore latencies in execute cycles
  localparam logic [2:0] RESTORE_FAST_CYC = 3'h3;
  localparam logic [2:0] RESTORE_SLOW_CYC = 3'h6;

  // =====================================================
  // Saved context: general_regs_upper plus special registers
  typedef struct packed {
    logic [GPR_COUNT-1:0][WORD_W-1:0] general_regs_upper;
    logic [WORD_W-1:0]                user_stack_pointer;
    logic [WORD_W-1:0]                float_status_word;
    logic [ACC_W-1:0]                 accumulator_zero;
    logic [ACC_W-1:0]                 accumulator_one;
  } rbs_ctx_s;

  typedef enum logic [1:0] {
    RBS_IDLE = 2'b00,
    RBS_BUSY = 2'b01
  } rbs_state_e;

endpackage

// [logic/rbs_unit.sv]
`timescale 1ns/1ns
module rbs_unit
  import rbs_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  // Save operation
  input  wire logic                save_req_in,
  input  wire logic [BANK_W-1:0]   save_bank_in,
  input  wire rbs_ctx_s            save_ctx_in,
  // Restore operation
  input  wire logic                bank_restore_op_in,
  input  wire logic [BANK_W-1:0]   restore_bank_in,
  // Status and results
  output logic                     busy_out,
  output logic                     restore_done_out,
  output logic                     restore_fast_out,
  output rbs_ctx_s                 restore_ctx_out
);

  // =====================================================
  // Storage
  rbs_ctx_s              bank_mem [BANK_COUNT];
  rbs_ctx_s              stage_ff;
  logic [BANK_W-1:0]     stage_bank_ff;
  logic                  stage_pend_ff;
  logic [BANK_W-1:0]     tag_ff;
  logic                  tag_vld_ff;
  rbs_state_e            state_ff;
  logic [2:0]            cnt_ff;
  logic                  fast_ff;
  logic [BANK_W-1:0]     rbank_ff;
  logic                  save_ok;
  logic                  rest_ok;
  logic                  hit;
  logic                  rest_last;

  // Operations are only taken while idle; caller honours busy_out
  assign save_ok  = save_req_in && (state_ff == RBS_IDLE);
  assign rest_ok  = bank_restore_op_in && (state_ff == RBS_IDLE) &&
                    !save_req_in;
  assign hit      = tag_vld_ff && (tag_ff == restore_bank_in);
  assign busy_out = (state_ff != RBS_IDLE);

  // =====================================================
  // Staging buffer: a save lands here in one cycle
  always_ff @(posedge mclk_in)
  begin
    if (save_ok)
    begin
      stage_ff      <= save_ctx_in;
      stage_bank_ff <= save_bank_in;
    end
  end

  // Drain to the bank one cycle later; no reset on contents
  always_ff @(posedge mclk_in)
  begin
    if (stage_pend_ff)
    begin
      bank_mem[stage_bank_ff] <= stage_ff;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      stage_pend_ff <= 1'b0;
    end
    else
    begin
      stage_pend_ff <= save_ok;
    end
  end

  // =====================================================
  // Tag of the most recent save
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      tag_ff <= 4'h0;
    end
    else if (save_ok)
    begin
      tag_ff <= save_bank_in;
    end
  end

  // Cleared by reset so an early restore takes the slow path
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      tag_vld_ff <= 1'b0;
    end
    else if (save_ok)
    begin
      tag_vld_ff <= 1'b1;
    end
  end

  // =====================================================
  // Restore sequencer
  assign rest_last = (state_ff == RBS_BUSY) && (cnt_ff == 3'h1);

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_ff <= RBS_IDLE;
    end
    else
    begin
      case (state_ff)
        RBS_IDLE:
        begin
          if (rest_ok)
          begin
            state_ff <= RBS_BUSY;
          end
        end
        RBS_BUSY:
        begin
          if (rest_last)
          begin
            state_ff <= RBS_IDLE;
          end
        end
        default:
        begin
          state_ff <= RBS_IDLE;
        end
      endcase
    end
  end

  // Cycles left; the issue cycle counts as the first one
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= 3'h0;
    end
    else if (rest_ok)
    begin
      cnt_ff <= hit ? RESTORE_FAST_CYC - 3'h1
                    : RESTORE_SLOW_CYC - 3'h1;
    end
    else if (state_ff == RBS_BUSY)
    begin
      cnt_ff <= cnt_ff - 3'h1;
    end
  end

  // Path and bank latched at issue; inputs may move while busy
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      fast_ff <= 1'b0;
    end
    else if (rest_ok)
    begin
      fast_ff <= hit;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rbank_ff <= 4'h0;
    end
    else if (rest_ok)
    begin
      rbank_ff <= restore_bank_in;
    end
  end

  // =====================================================
  // Result registers; bank array has no other read port
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      restore_done_out <= 1'b0;
    end
    else
    begin
      restore_done_out <= rest_last;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      restore_fast_out <= 1'b0;
    end
    else if (rest_last)
    begin
      restore_fast_out <= fast_ff;
    end
  end

  // Buffer may already have drained; its copy is still identical
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      restore_ctx_out <= '0;
    end
    else if (rest_last)
    begin
      restore_ctx_out <= fast_ff ? stage_ff
                                 : bank_mem[rbank_ff];
    end
  end

endmodule

// [verif/rbs_cpu_model.sv]
`timescale 1ns/1ns
module rbs_cpu_model
  import rbs_pkg::*;
(
  // Selection
  input  wire logic [BANK_W-1:0] bank_in,
  input  wire logic [3:0]        gen_in,
  // Context
  output rbs_ctx_s               ctx_out
);
  // Context tied to bank, so restore pairs with its save
  assign ctx_out = {86{gen_in, bank_in}};
endmodule

// [verif/rbs_unit_assertions.sv]
`timescale 1ns/1ns
module rbs_unit_assertions
  import rbs_pkg::*;
(
  input wire logic              mclk_in,
  input wire logic              rst_in,
  input wire logic              save_req_in,
  input wire logic [BANK_W-1:0] save_bank_in,
  input wire logic              bank_restore_op_in,
  input wire logic [BANK_W-1:0] restore_bank_in,
  input wire logic              busy_out,
  input wire logic              restore_done_out,
  input wire logic              restore_fast_out,
  input wire rbs_ctx_s          restore_ctx_out
);
  logic [BANK_W-1:0] tag_ff;
  logic              val_ff;
  wire logic sv = save_req_in && !busy_out;
  wire logic acc = bank_restore_op_in && !busy_out && !save_req_in;
  wire logic hit = acc && val_ff && restore_bank_in == tag_ff;
  always_ff @(posedge mclk_in)
  begin
    if (sv) tag_ff <= save_bank_in;
    val_ff <= !rst_in && (val_ff || sv);
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_fast;
    busy_out[*2] ##1 restore_done_out && restore_fast_out;
  endsequence
  sequence s_slow;
    busy_out[*5] ##1 restore_done_out && !restore_fast_out;
  endsequence
  AST_HIT: assert property (hit |=> s_fast)
    else $error("hit");
  AST_MISS: assert property (acc && !hit |=> s_slow)
    else $error("miss");
  AST_DONE: assert property (restore_done_out |=> !restore_done_out)
    else $error("done");
  AST_CTX: assert property
    (!restore_done_out |-> $stable(restore_ctx_out))
    else $error("ctx");
  AST_IDLE: assert property (!acc && !busy_out |=> !busy_out)
    else $error("idle");
  AST_FELL: assert property ($fell(busy_out) |-> restore_done_out)
    else $error("fell");
endmodule
bind rbs_unit rbs_unit_assertions rbs_unit_assertions_inst (.mclk_in,
  .rst_in, .save_req_in, .save_bank_in, .bank_restore_op_in,
  .restore_bank_in, .busy_out, .restore_done_out, .restore_fast_out,
  .restore_ctx_out);

// [verif/rbs_unit_tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
  mismatches++; $display("BAD %0t %h %h", $time, a, e); end end
module rbs_unit_tb import rbs_pkg::*;;
  logic       mclk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       save_req_in = 1'b0;
  logic       bank_restore_op_in = 1'b0;
  logic [3:0] mb = 4'h0;
  logic [3:0] gen = 4'h0;
  logic       busy_out;
  logic       restore_done_out;
  logic       restore_fast_out;
  rbs_ctx_s   save_ctx_in;
  rbs_ctx_s   restore_ctx_out;
  int         mismatches = 0;
  int         cmp_count = 0;
  logic [4:0] rows [4] = '{5'h1F, 5'h06, 5'h00, 5'h1F};
  always #20 mclk_in = ~mclk_in;
  rbs_unit rbs_unit_inst (.mclk_in, .rst_in, .save_req_in,
    .save_bank_in(mb), .save_ctx_in, .bank_restore_op_in,
    .restore_bank_in(mb), .busy_out, .restore_done_out,
    .restore_fast_out, .restore_ctx_out);
  rbs_cpu_model rbs_cpu_model_inst (.bank_in(mb), .gen_in(gen),
    .ctx_out(save_ctx_in));
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    `CHK({busy_out, restore_done_out, restore_fast_out}, 3'h0)
  endtask
  task automatic restore(input logic [3:0] b, input logic f);
    int n;
    @(negedge mclk_in);
    mb = b;
    bank_restore_op_in = 1'b1;
    @(negedge mclk_in);
    bank_restore_op_in = 1'b0;
    n = 1;
    while (restore_done_out !== 1'b1 && n < 9)
    begin
      @(negedge mclk_in);
      n++;
    end
    `CHK(n, f ? 3 : 6)
    if (n == 9) summarize();
    `CHK(restore_fast_out, f)
    `CHK(restore_ctx_out, save_ctx_in)
  endtask
  initial
  begin
    do_reset();
    save_req_in = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      mb = 4'(i);
      @(negedge mclk_in);
    end
    save_req_in = 1'b0;
    foreach (rows[i])
      restore(rows[i][4:1], rows[i][0]);
    gen = 4'h1;
    mb = 4'h9;
    save_req_in = 1'b1;
    bank_restore_op_in = 1'b1;
    @(negedge mclk_in);
    save_req_in = 1'b0;
    bank_restore_op_in = 1'b0;
    repeat (2) @(negedge mclk_in) `CHK(busy_out, 1'b0)
    restore(4'h9, 1'b1);
    do_reset();
    restore(4'h9, 1'b0);
    summarize();
  end
endmodule
